// ### tmc_pkg.sv
`default_nettype none
package tmc_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] CTRL_OFF  = 8'h00;
  localparam logic [7:0] COUNT_OFF = 8'h01;
  localparam logic [7:0] CMP_OFF   = 8'h02;
  localparam logic [7:0] STAT_OFF  = 8'h03;
  localparam logic [7:0] MASK_OFF  = 8'h04;

  // Control register field positions
  localparam int FORCE_POS  = 7;
  localparam int WGM_LO_POS = 6;
  localparam int ACT_HI_POS = 5;
  localparam int ACT_LO_POS = 4;
  localparam int WGM_HI_POS = 3;
  localparam int CS_HI_POS  = 2;
  localparam int CS_LO_POS  = 0;

  // Status and mask bit positions
  localparam int OVF_BIT  = 0;
  localparam int CMPF_BIT = 1;

  // Reset values
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] CMP_RESET   = 8'h00;
  localparam logic [1:0] STAT_RESET  = 2'h0;
  localparam logic [1:0] MASK_RESET  = 2'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // Counter extremes
  localparam logic [7:0] MAX_VAL    = 8'hff;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;

  // Prescaler: free-running 10-bit counter, taps fire when low bits are all ones
  localparam int          PRESC_W      = 10;
  localparam logic [9:0] PRESC_RESET  = 10'h000;
  localparam logic [9:0] DIV8_MASK    = 10'h007;
  localparam logic [9:0] DIV64_MASK   = 10'h03f;
  localparam logic [9:0] DIV256_MASK  = 10'h0ff;
  localparam logic [9:0] DIV1024_MASK = 10'h3ff;

  // Pin edge to counter update, in whole system clock cycles
  localparam int EXT_LAT_CYC = 3;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_PC     = 2'b01,
    MODE_CLEAR  = 2'b10,
    MODE_FAST   = 2'b11
  } tmc_mode_t;

  typedef enum logic [1:0] {
    ACT_OFF = 2'b00,
    ACT_TOG = 2'b01,
    ACT_CLR = 2'b10,
    ACT_SET = 2'b11
  } tmc_act_t;

  typedef enum logic [2:0] {
    CS_STOP     = 3'b000,
    CS_DIV1     = 3'b001,
    CS_DIV8     = 3'b010,
    CS_DIV64    = 3'b011,
    CS_DIV256   = 3'b100,
    CS_DIV1024  = 3'b101,
    CS_EXT_FALL = 3'b110,
    CS_EXT_RISE = 3'b111
  } tmc_cs_t;
endpackage : tmc_pkg
`default_nettype wire

// ### tmc_tick_if.sv
`default_nettype none
// Clock source selection and the resulting timer tick
interface tmc_tick_if;
  logic [2:0] clk_src_sel;
  logic       count_tick;
  modport src  (input clk_src_sel, output count_tick);
  modport sink (output clk_src_sel, input count_tick);
endinterface : tmc_tick_if
`default_nettype wire

// ### tmc_clk_sel.sv
`default_nettype none
module tmc_clk_sel
  import tmc_pkg::*;
(
  input wire logic  clk,
  input wire logic  rst_n,
  input wire logic  ext_pin,
  tmc_tick_if.src   tick
);
  logic [PRESC_W-1:0] presc_reg;
  logic               ext_meta_reg;
  logic               ext_sync_reg;
  logic               ext_prev_reg;
  logic               rise_det;
  logic               fall_det;

  // Free-running prescaler, unaffected by the clock select
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_reg <= PRESC_RESET;
    end else begin
      presc_reg <= presc_reg + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_meta_reg <= ext_pin;
      ext_sync_reg <= ext_meta_reg;
      ext_prev_reg <= ext_sync_reg;
    end
  end

  assign rise_det = ext_sync_reg & ~ext_prev_reg;
  assign fall_det = ~ext_sync_reg & ext_prev_reg;

  // tick source per clock select code
  always_comb begin
    unique case (tmc_cs_t'(tick.clk_src_sel))
      CS_STOP:     tick.count_tick = 1'b0;
      CS_DIV1:     tick.count_tick = 1'b1;
      CS_DIV8:     tick.count_tick = (presc_reg & DIV8_MASK) == DIV8_MASK;
      CS_DIV64:    tick.count_tick = (presc_reg & DIV64_MASK) == DIV64_MASK;
      CS_DIV256:   tick.count_tick = (presc_reg & DIV256_MASK) == DIV256_MASK;
      CS_DIV1024:  tick.count_tick = presc_reg == DIV1024_MASK;
      CS_EXT_FALL: tick.count_tick = fall_det;
      CS_EXT_RISE: tick.count_tick = rise_det;
    endcase
  end

  sequence sync_rise_s;
    (tick.clk_src_sel == CS_EXT_RISE) ##0 $rose(ext_sync_reg);
  endsequence

  // synced rising edge gives one tick
  ext_rise_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
    sync_rise_s |-> tick.count_tick ##1 (!tick.count_tick || tick.clk_src_sel != CS_EXT_RISE))
    else $error("external rising edge did not give exactly one tick");
endmodule // tmc_clk_sel
`default_nettype wire

// ### tmc_top.sv
// Functional notes
// - Force strobe acts only in non-PWM modes.
// - Force applies compare match to waveform immediately.
// - Force is one-shot; uses written action field.
// - Force sets no flag, never clears counter.
// - Force strobe bit always reads zero.
// - Mode bits at positions 6 and 3.
// - Normal, phase-correct, clear-on-match, fast PWM tops.
// - Compare update and overflow point per mode.
// - Nonzero action field takes over the pin.
// - Non-PWM actions: off, toggle, clear, set.
// - Fast PWM: clear/set on match, opposite at top.
// - Phase-correct: action by count direction.
// - Compare equal top: skip match, keep top action.
// - Clock select: stop, direct, four taps, external.
// - External pin counts even when driven out.
// - External input synced, 2-3 cycles latency.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`default_nettype none
module tmc_top
  import tmc_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RESET_N,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       EXT_COUNT_PIN,
  output logic            CMP_WAVE_OUT,
  output logic            CMP_WAVE_OE,
  output logic            IRQ
);
  logic [7:0] ctrl_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] cmp_buf_reg;
  logic [7:0] cmp_active_reg;
  logic       dir_up_reg;
  logic       block_reg;
  logic       wave_reg;
  logic       wave_next;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  tmc_mode_t  mode;
  tmc_act_t   action;
  tmc_act_t   wr_action;
  logic       pwm;
  logic       tick;
  logic [7:0] top_val;
  logic       wr_ctrl;
  logic       wr_count;
  logic       wr_cmp;
  logic       wr_stat;
  logic       wr_mask;
  logic       force_cmp;
  logic       match_raw;
  logic       match_ignore;
  logic       match;
  logic       at_max;
  logic       ovf_evt;

  tmc_tick_if tick_if ();

  // Clock source selection and external pin conditioning
  tmc_clk_sel u_clk_sel (
    .clk     (MCLK),
    .rst_n   (RESET_N),
    .ext_pin (EXT_COUNT_PIN),
    .tick    (tick_if.src)
  );

  // select field drives the tick source
  assign tick_if.clk_src_sel = ctrl_reg[CS_HI_POS:CS_LO_POS];
  assign tick                = tick_if.count_tick;

  // Register port decode
  assign wr_ctrl  = WR && (ADDR == CTRL_OFF);
  assign wr_count = WR && (ADDR == COUNT_OFF);
  assign wr_cmp   = WR && (ADDR == CMP_OFF);
  assign wr_stat  = WR && (ADDR == STAT_OFF);
  assign wr_mask  = WR && (ADDR == MASK_OFF);

  // mode bits split across positions 6 and 3
  assign mode      = tmc_mode_t'({ctrl_reg[WGM_HI_POS], ctrl_reg[WGM_LO_POS]});
  assign action    = tmc_act_t'(ctrl_reg[ACT_HI_POS:ACT_LO_POS]);
  assign wr_action = tmc_act_t'(WDATA[ACT_HI_POS:ACT_LO_POS]);
  assign pwm       = (mode == MODE_PC) || (mode == MODE_FAST);

  // only clear-on-match takes its top from the compare value
  assign top_val = (mode == MODE_CLEAR) ? cmp_active_reg : MAX_VAL;

  // strobe honoured only when the written mode is non-PWM
  assign force_cmp = wr_ctrl && WDATA[FORCE_POS] && !WDATA[WGM_LO_POS];

  // Match events; a counter write masks the next tick's match
  assign match_raw    = tick && (count_reg == cmp_active_reg) && !block_reg;
  // in PWM modes, compare at top with upper action bit set is skipped
  assign match_ignore = pwm && action[1] && (cmp_active_reg == MAX_VAL);
  assign match        = match_raw && !match_ignore;
  assign at_max       = tick && (count_reg == MAX_VAL);

  // overflow at bottom in phase-correct, at max elsewhere
  assign ovf_evt = tick && ((mode == MODE_PC) ? (!dir_up_reg && count_reg == BOTTOM_VAL)
                                               : (count_reg == MAX_VAL));

  // Control register; force bit is never stored
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_reg <= {1'b0, WDATA[6:0]};
    end
  end

  // Count sequence per waveform mode
  always_comb begin
    count_next = count_reg;
    unique case (mode)
      MODE_NORMAL, MODE_FAST: begin
        count_next = (count_reg == MAX_VAL) ? BOTTOM_VAL : count_reg + 8'h01;
      end
      MODE_CLEAR: begin
        count_next = (count_reg == top_val) ? BOTTOM_VAL : count_reg + 8'h01;
      end
      MODE_PC: begin
        if (dir_up_reg) begin
          count_next = (count_reg == MAX_VAL) ? count_reg - 8'h01 : count_reg + 8'h01;
        end else begin
          count_next = (count_reg == BOTTOM_VAL) ? count_reg + 8'h01 : count_reg - 8'h01;
        end
      end
    endcase
  end

  // a forced compare never touches the counter
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      count_reg <= COUNT_RESET;
    end else if (wr_count) begin
      count_reg <= WDATA;
    end else if (tick) begin
      count_reg <= count_next;
    end
  end

  // Direction for dual-slope counting; up in every other mode
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dir_up_reg <= 1'b1;
    end else if (mode != MODE_PC) begin
      dir_up_reg <= 1'b1;
    end else if (tick && !wr_count) begin
      if (dir_up_reg && count_reg == MAX_VAL) begin
        dir_up_reg <= 1'b0;
      end else if (!dir_up_reg && count_reg == BOTTOM_VAL) begin
        dir_up_reg <= 1'b1;
      end
    end
  end

  // Match blocking after a counter write; the write wins over the release
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      block_reg <= 1'b0;
    end else if (wr_count) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  // Compare buffer as written by software
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cmp_buf_reg <= CMP_RESET;
    end else if (wr_cmp) begin
      cmp_buf_reg <= WDATA;
    end
  end

  // immediate update in non-PWM, at top in PWM to avoid glitched pulses
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cmp_active_reg <= CMP_RESET;
    end else if (!pwm) begin
      cmp_active_reg <= cmp_buf_reg;
    end else if (at_max) begin
      cmp_active_reg <= cmp_buf_reg;
    end
  end

  // Waveform generator next state
  always_comb begin
    wave_next = wave_reg;
    if (force_cmp) begin
      // forced match, action taken from the written value
      unique case (wr_action)
        ACT_OFF: wave_next = wave_reg;
        ACT_TOG: wave_next = ~wave_reg;
        ACT_CLR: wave_next = 1'b0;
        ACT_SET: wave_next = 1'b1;
      endcase
    end else begin
      unique case (mode)
        MODE_NORMAL, MODE_CLEAR: begin
          if (match) begin
            unique case (action)
              ACT_OFF: wave_next = wave_reg;
              ACT_TOG: wave_next = ~wave_reg;
              ACT_CLR: wave_next = 1'b0;
              ACT_SET: wave_next = 1'b1;
            endcase
          end
        end
        // match then opposite level at top
        MODE_FAST: begin
          if (match) begin
            unique case (action)
              ACT_OFF: wave_next = wave_reg;
              ACT_TOG: wave_next = ~wave_reg;
              ACT_CLR: wave_next = 1'b0;
              ACT_SET: wave_next = 1'b1;
            endcase
          end
          if (at_max && action[1]) begin
            wave_next = (action == ACT_CLR);
          end
        end
        MODE_PC: begin
          if (match && action[1]) begin
            wave_next = dir_up_reg ? (action == ACT_SET) : (action == ACT_CLR);
          end
          // compare at max still settles the output at top
          if (at_max && action[1] && cmp_active_reg == MAX_VAL) begin
            wave_next = (action == ACT_CLR);
          end
        end
      endcase
    end
  end

  // Registered level, so the pin never glitches
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wave_reg <= 1'b0;
    end else begin
      wave_reg <= wave_next;
    end
  end

  // any nonzero action takes the pin from the port
  assign CMP_WAVE_OUT = wave_reg;
  assign CMP_WAVE_OE  = (action != ACT_OFF);

  // Sticky flags; a new event beats a write-one clear in the same cycle
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      status_reg <= STAT_RESET;
    end else begin
      status_reg <= (status_reg & ~(wr_stat ? WDATA[1:0] : 2'h0))
                  | {match_raw, ovf_evt};
    end
  end

  // Interrupt mask, same layout as the flags
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mask_reg <= MASK_RESET;
    end else if (wr_mask) begin
      mask_reg <= WDATA[1:0];
    end
  end

  // Level interrupt while any unmasked flag is set
  assign IRQ = |(status_reg & mask_reg);

  // Read mux; data valid only in the cycle after the strobe
  always_comb begin
    rdata_next = RDATA_RESET;
    if (RD) begin
      unique case (ADDR)
        // force bit is never stored so reads zero
        CTRL_OFF:  rdata_next = {1'b0, ctrl_reg[6:0]};
        COUNT_OFF: rdata_next = count_reg;
        CMP_OFF:   rdata_next = cmp_buf_reg;
        STAT_OFF:  rdata_next = {6'h00, status_reg};
        MASK_OFF:  rdata_next = {6'h00, mask_reg};
        default:   rdata_next = RDATA_RESET;
      endcase
    end
  end

  // Read data register, zero when no read
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_reg <= RDATA_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign RDATA = rdata_reg;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);

  sequence fc_pwm_write_s;
    wr_ctrl && WDATA[FORCE_POS] && WDATA[WGM_LO_POS] && !tick;
  endsequence
  sequence fc_clr_write_s;
    wr_ctrl && WDATA[FORCE_POS] && !WDATA[WGM_LO_POS] && (wr_action == ACT_CLR);
  endsequence
  sequence fc_set_write_s;
    wr_ctrl && WDATA[FORCE_POS] && !WDATA[WGM_LO_POS] && (wr_action == ACT_SET);
  endsequence

  force_in_pwm_a: assert property (fc_pwm_write_s |=> $stable(wave_reg))
    else $error("force strobe changed output in a PWM mode");
  force_clear_a: assert property (fc_clr_write_s |=> !wave_reg)
    else $error("forced compare with clear action left output high");
  // A back-to-back control write may legally move the output again
  force_set_a: assert property (fc_set_write_s ##1 (!tick && !wr_ctrl) [*2] |-> wave_reg)
    else $error("forced compare with set action did not hold output high");
  force_no_side_a: assert property (force_cmp && !tick && !wr_count |=>
    $stable(count_reg) && $stable(status_reg))
    else $error("forced compare changed counter or flags");
  force_reads_zero_a: assert property (RD && ADDR == CTRL_OFF |=> !RDATA[FORCE_POS])
    else $error("force strobe bit read back as one");
  match_clear_a: assert property (mode == MODE_CLEAR && tick && !wr_count
    && count_reg == cmp_active_reg |=> count_reg == BOTTOM_VAL)
    else $error("clear-on-match counter not cleared at compare top");
  cmp_hold_pwm_a: assert property (pwm && !at_max && $past(pwm) |=> $stable(cmp_active_reg))
    else $error("PWM compare value changed away from top");
  pc_ovf_bottom_a: assert property (mode == MODE_PC && tick && !dir_up_reg
    && count_reg == BOTTOM_VAL |=> status_reg[OVF_BIT])
    else $error("phase-correct overflow not flagged at bottom");

  pin_override_a: assert property (CMP_WAVE_OE == (ctrl_reg[ACT_HI_POS:ACT_LO_POS] != 2'b00))
    else $error("pin override does not follow action field");

  fast_top_a: assert property (mode == MODE_FAST && action == ACT_CLR && at_max
    && !wr_ctrl |=> wave_reg)
    else $error("fast PWM did not set output at top");

  pc_up_match_a: assert property (mode == MODE_PC && action == ACT_CLR && match
    && dir_up_reg && !wr_ctrl |=> !wave_reg)
    else $error("phase-correct up match did not clear output");

  stopped_a: assert property (ctrl_reg[CS_HI_POS:CS_LO_POS] == CS_STOP |-> !tick)
    else $error("timer ticked while stopped");

  reset_ctrl_a: assert property ($rose(RESET_N) |-> ctrl_reg == CTRL_RESET && !CMP_WAVE_OE)
    else $error("control not cleared by reset");
endmodule // tmc_top
`default_nettype wire

// ### tmc_pin_model.sv
`default_nettype none
// Far side: drives the count pin, watches the waveform pin
module tmc_pin_model (
  input  wire logic clk,
  input  wire logic wave,
  input  wire logic wave_oe,
  output var logic  pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle low until a pulse train is asked for
  initial pin = 1'b0;

  // Each level held 3 cycles, well above the sampling limit
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      pin <= 1'b1;
      repeat (3) @(posedge clk);
      pin <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask

  task automatic measure(input int n, output int highs);
    highs = 0;
    repeat (n) begin
      @(posedge clk);
      if (wave_oe === 1'b1 && wave === 1'b1) highs++;
    end
  endtask
endmodule // tmc_pin_model
`default_nettype wire

// ### tb.sv
`default_nettype none
module tb
  import tmc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic       mclk;
  logic       reset_n;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr_s;
  logic       rd_s;
  logic [7:0] rdata;
  logic       ext_pin;
  logic       wave;
  logic       wave_oe;
  logic       irq;
  int         err_total;
  int         checked;
  int         cyc;
  int         divs [5] = '{1, 8, 64, 256, 1024};
  logic [7:0] va;
  logic [7:0] vb;
  logic [7:0] frc [4] = '{8'hb0, 8'ha0, 8'h90, 8'h90};
  logic       fw [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  tmc_top uut (
    .MCLK          (mclk),
    .RESET_N       (reset_n),
    .ADDR          (addr),
    .WDATA         (wdata),
    .WR            (wr_s),
    .RD            (rd_s),
    .RDATA         (rdata),
    .EXT_COUNT_PIN (ext_pin),
    .CMP_WAVE_OUT  (wave),
    .CMP_WAVE_OE   (wave_oe),
    .IRQ           (irq)
  );

  tmc_pin_model pm (
    .clk     (mclk),
    .wave    (wave),
    .wave_oe (wave_oe),
    .pin     (ext_pin)
  );

  // 125 MHz system clock
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  task automatic wrap_up();
    if (err_total == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, far above the expected run length
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge mclk);
    wr_s  <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    reg_rd(a, v);
    chk(v, exp);
  endtask

  // Duty check; range allows for edge alignment of the window
  task automatic pwm(input logic [7:0] c, input logic [7:0] cv, input int w,
                     input int lo, input int hi);
    int h;
    reg_wr(CTRL_OFF, 8'h00);
    reg_wr(CMP_OFF, cv);
    reg_wr(CTRL_OFF, c);
    repeat (600) @(posedge mclk);
    pm.measure(w, h);
    chk({7'h00, (h >= lo && h <= hi)}, 8'h01);
  endtask

  // Main sequence
  initial begin
    reset_n = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    #1 chk({5'h00, wave, wave_oe, irq}, 8'h00);
    for (int a = 0; a < 8; a++) rdchk(8'(a), 8'h00);
    // Direct clock and prescaler taps: exact tick count over two periods
    for (int i = 0; i < 5; i++) begin
      reg_wr(CTRL_OFF, {5'h00, 3'(CS_DIV1 + i)});
      reg_rd(COUNT_OFF, va);
      repeat (2 * divs[i] - 2) @(posedge mclk);
      reg_rd(COUNT_OFF, vb);
      chk(8'(vb - va), 8'h02);
    end
    reg_wr(CTRL_OFF, 8'h00);
    reg_rd(COUNT_OFF, va);
    repeat (20) @(posedge mclk);
    rdchk(COUNT_OFF, va);
    // External edges, rising then falling
    for (int e = 0; e < 2; e++) begin
      reg_wr(CTRL_OFF, {5'h00, (e == 0) ? CS_EXT_RISE : CS_EXT_FALL});
      reg_rd(COUNT_OFF, va);
      pm.pulse(5);
      repeat (6) @(posedge mclk);
      reg_rd(COUNT_OFF, vb);
      chk(8'(vb - va), 8'h05);
    end
    // Overflow and compare flags, mask and clear
    reg_wr(CTRL_OFF, 8'h00);
    reg_wr(STAT_OFF, 8'h03);
    reg_wr(COUNT_OFF, 8'hf0);
    reg_wr(CTRL_OFF, 8'h01);
    repeat (30) @(posedge mclk);
    reg_wr(CTRL_OFF, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rdchk(STAT_OFF, 8'h03);
    reg_wr(MASK_OFF, 8'h01);
    #1 chk({7'h00, irq}, 8'h01);
    reg_wr(STAT_OFF, 8'h01);
    #1 chk({7'h00, irq}, 8'h00);
    reg_wr(MASK_OFF, 8'h02);
    #1 chk({7'h00, irq}, 8'h01);
    reg_wr(STAT_OFF, 8'h02);
    #1 chk({7'h00, irq}, 8'h00);
    // Forced matches in normal mode: set, clear, toggle twice
    for (int f = 0; f < 4; f++) begin
      reg_wr(CTRL_OFF, frc[f]);
      @(posedge mclk);
      #1 chk({6'h00, wave, wave_oe}, {6'h00, fw[f], 1'b1});
    end
    rdchk(CTRL_OFF, 8'h10);
    rdchk(STAT_OFF, 8'h00);
    // Forced toggle in clear-on-match mode leaves the counter alone
    reg_wr(CMP_OFF, 8'h05);
    reg_wr(COUNT_OFF, 8'h33);
    reg_wr(CTRL_OFF, 8'h98);
    @(posedge mclk);
    #1 chk({7'h00, wave}, 8'h01);
    rdchk(COUNT_OFF, 8'h33);
    rdchk(STAT_OFF, 8'h00);
    // Strobe written in both PWM modes on purpose, expecting no effect
    reg_wr(CTRL_OFF, 8'he0);
    reg_wr(CTRL_OFF, 8'he8);
    @(posedge mclk);
    #1 chk({7'h00, wave}, 8'h01);
    reg_wr(CTRL_OFF, 8'h00);
    #1 chk({7'h00, wave_oe}, 8'h00);
    // Clear-on-match top at the compare value
    reg_wr(COUNT_OFF, 8'h00);
    reg_wr(CMP_OFF, 8'h04);
    reg_wr(CTRL_OFF, 8'h09);
    for (int k = 0; k < 6; k++) begin
      reg_rd(COUNT_OFF, va);
      chk({7'h00, va <= 8'h04}, 8'h01);
    end
    pwm(8'h69, 8'h40, 512, 124, 136);
    pwm(8'h79, 8'h40, 512, 376, 388);
    pwm(8'h69, 8'hff, 512, 510, 512);
    pwm(8'h61, 8'h40, 1020, 248, 264);
    pwm(8'h71, 8'h40, 1020, 756, 772);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
